/* rtl/fwsr_bus_cycle.sv */
/*
 * One read or write cycle on the parallel flash pins.
 * Assumes the flash answers within the strobe time; data lines come back
 * through a two-flop synchroniser before they are sampled.
 */
`timescale 1ns/100ps
module fwsr_bus_cycle #(
   parameter int STROBE_CYC = fwsr_pkg::STRB_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_go,
   input wire logic i_wr,
   input wire logic [16:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic o_done,
   output logic [7:0] o_rdata,
   output logic [16:0] o_fl_addr,
   output logic o_fl_ce_n,
   output logic o_fl_oe_n,
   output logic o_fl_we_n,
   output logic [7:0] o_fl_dq_out,
   output logic o_fl_dq_oe,
   input wire logic [7:0] i_fl_dq_in
);
   import fwsr_pkg::*;

   typedef enum logic [2:0] {
      BC_IDLE = 3'b001,
      BC_STRB = 3'b010,
      BC_RCV = 3'b100
   } fwsr_bc_e;

   if (STROBE_CYC < 1 || STROBE_CYC + SYNC_CYC > 15) begin : g_bad_strobe
      $error("fwsr_bus_cycle: STROBE_CYC out of range");
   end

   fwsr_bc_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic wr, next_wr;
   logic [7:0] dq_s1, dq_s2;
   logic next_done, next_ce_n, next_oe_n, next_we_n, next_dq_oe;
   logic [7:0] next_rdata, next_dq_out;
   logic [16:0] next_fl_addr;

   // Data lines pass two flops before anything reads them
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
      end else begin
         dq_s1 <= i_fl_dq_in;
         dq_s2 <= dq_s1;
      end
   end

   // Strobe sequencer; reads stay low longer to cover the synchroniser
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_wr = wr;
      next_done = 1'b0;
      next_rdata = o_rdata;
      next_fl_addr = o_fl_addr;
      next_ce_n = o_fl_ce_n;
      next_oe_n = o_fl_oe_n;
      next_we_n = o_fl_we_n;
      next_dq_out = o_fl_dq_out;
      next_dq_oe = o_fl_dq_oe;
      case (state)
         BC_IDLE: begin
            if (i_go) begin
               next_state = BC_STRB;
               next_wr = i_wr;
               next_fl_addr = i_addr;
               next_ce_n = 1'b0;
               next_oe_n = i_wr;
               next_we_n = !i_wr;
               next_dq_out = i_wdata;
               next_dq_oe = i_wr;
               next_cnt = i_wr ? 4'(STROBE_CYC - 1) : 4'(STROBE_CYC + SYNC_CYC - 1);
            end
         end
         BC_STRB: begin
            if (cnt == 4'h0) begin
               // Rising strobe latches write data; read data sampled here
               next_state = BC_RCV;
               next_ce_n = 1'b1;
               next_oe_n = 1'b1;
               next_we_n = 1'b1;
               next_cnt = 4'(REC_CYC - 1);
               if (!wr) begin
                  next_rdata = dq_s2;
               end
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         BC_RCV: begin
            // Data held one cycle past the rising edge for hold time
            if (cnt == 4'h0) begin
               next_state = BC_IDLE;
               next_dq_oe = 1'b0;
               next_done = 1'b1;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         default: begin
            next_state = BC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= BC_IDLE;
         cnt <= 4'h0;
         wr <= 1'b0;
         o_done <= 1'b0;
         o_rdata <= 8'h00;
         o_fl_addr <= 17'h00000;
         o_fl_ce_n <= 1'b1;
         o_fl_oe_n <= 1'b1;
         o_fl_we_n <= 1'b1;
         o_fl_dq_out <= 8'h00;
         o_fl_dq_oe <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         wr <= next_wr;
         o_done <= next_done;
         o_rdata <= next_rdata;
         o_fl_addr <= next_fl_addr;
         o_fl_ce_n <= next_ce_n;
         o_fl_oe_n <= next_oe_n;
         o_fl_we_n <= next_we_n;
         o_fl_dq_out <= next_dq_out;
         o_fl_dq_oe <= next_dq_oe;
      end
   end

   // Output and write strobes never low together
   a_strobe_excl: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !(!o_fl_oe_n && !o_fl_we_n)) else $error("oe and we low together");
endmodule

/* rtl/fwsr_pkg.sv */
/*
 * Constants shared by the flash status poller: register map, command bits,
 * status bit positions on the flash data lines, and pin timing counts.
 * Assumes a 40 MHz controller clock.
 */
package fwsr_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_ADDR = 5'h04;
   localparam logic [4:0] REG_WDATA = 5'h08;
   localparam logic [4:0] REG_STATUS = 5'h0c;
   localparam logic [4:0] REG_RDATA = 5'h10;
   // Command bits in the control register
   localparam int CMD_POLL = 0;
   localparam int CMD_RST = 1;
   localparam int CMD_WR = 2;
   localparam int CMD_RD = 3;
   // Status bit positions on the flash data lines
   localparam int POLL_BIT = 7;
   localparam int PTOG_BIT = 6;
   localparam int TOUT_BIT = 5;
   localparam int ESTART_BIT = 3;
   localparam int ESTOG_BIT = 2;
   // Reset values
   localparam logic [16:0] ADDR_RST = 17'h00000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Pin timing: strobe low time rounds up, recovery is one cycle
   localparam int CLK_PERIOD_NS = 25;
   localparam int CYCLE_NS = 70;
   localparam int STRB_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_CYC = 2;
   localparam int REC_CYC = 1;
endpackage

/* rtl/fwsr_poller.sv */
/*
 * Host side controller for a parallel NOR flash: runs the toggle-bit
 * status polling algorithm, issues the reset command on failure, and
 * performs single byte reads and writes on software request.
 * Assumes an AXI4-Lite master on the same clock and a flash whose pins
 * are wired straight to the fl ports.
 */
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// - After timeout failure host writes reset command
// - On timeout bit, host rechecks toggling
// - Host reads twice, compares toggle bit
// - Still toggling with timeout: fail, issue reset
// - Resumed polling restarts algorithm from top
module fwsr_poller #(
   parameter logic [7:0] RESET_CMD = 8'hf0
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [4:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [4:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [16:0] o_fl_addr,
   output logic o_fl_ce_n,
   output logic o_fl_oe_n,
   output logic o_fl_we_n,
   output logic [7:0] o_fl_dq_out,
   output logic o_fl_dq_oe,
   input wire logic [7:0] i_fl_dq_in
);
   import fwsr_pkg::*;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_RD1 = 7'b0000010,
      ST_RD2 = 7'b0000100,
      ST_RD3 = 7'b0001000,
      ST_RD4 = 7'b0010000,
      ST_RST = 7'b0100000,
      ST_ONE = 7'b1000000
   } fwsr_st_e;

   // Merge a written word into a register under byte strobes
   function automatic logic [31:0] fwsr_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   logic aw_full, next_aw_full, w_full, next_w_full;
   logic [4:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [16:0] addr_reg, next_addr_reg;
   logic [7:0] wbyte, next_wbyte;
   logic [3:0] cmd, next_cmd;
   logic [31:0] status;

   fwsr_st_e state, next_state;
   logic go, next_go, wr, next_wr, t1, next_t1;
   logic done, next_done, fail, next_fail, tout_seen, next_tout;
   logic from_poll, next_from_poll;
   logic [7:0] bdata, next_bdata, last_rd, next_last_rd;
   logic [1:0] rd_cnt, next_rd_cnt;
   logic bc_done;
   logic [7:0] bc_rdata;

   assign status = {16'h0000, last_rd, 4'h0, tout_seen, fail, done, state != ST_IDLE};

   // AXI4-Lite slave; address and data are taken in either order
   always_comb begin
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full = w_full;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = o_bvalid;
      next_bresp = o_bresp;
      next_arready = o_arready;
      next_rvalid = o_rvalid;
      next_rresp = o_rresp;
      next_rdata = o_rdata;
      next_addr_reg = addr_reg;
      next_wbyte = wbyte;
      next_cmd = 4'h0;
      if (i_awvalid && o_awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         next_w_full = 1'b1;
         next_w_data = i_wdata;
         next_w_strb = i_wstrb;
      end
      if (o_bvalid && i_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_full && w_full && !o_bvalid) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         case ({aw_addr[4:2], 2'b00})
            REG_CTRL: next_cmd = w_strb[0] ? w_data[3:0] : 4'h0;
            REG_ADDR: next_addr_reg = 17'(fwsr_merge({15'h0000, addr_reg}, w_data, w_strb));
            REG_WDATA: next_wbyte = 8'(fwsr_merge({24'h000000, wbyte}, w_data, w_strb));
            REG_STATUS, REG_RDATA: next_bresp = RESP_OKAY;
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      if (o_rvalid && i_rready) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
      if (i_arvalid && o_arready) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         case ({i_araddr[4:2], 2'b00})
            REG_CTRL: next_rdata = 32'h00000000;
            REG_ADDR: next_rdata = {15'h0000, addr_reg};
            REG_WDATA: next_rdata = {24'h000000, wbyte};
            REG_STATUS: next_rdata = status;
            REG_RDATA: next_rdata = {24'h000000, last_rd};
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      next_awready = !next_aw_full;
      next_wready = !next_w_full;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_full <= 1'b0;
         aw_addr <= 5'h00;
         w_full <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rresp <= RESP_OKAY;
         o_rdata <= 32'h00000000;
         addr_reg <= ADDR_RST;
         wbyte <= BYTE_RST;
         cmd <= 4'h0;
      end else begin
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full <= next_w_full;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         o_awready <= next_awready;
         o_wready <= next_wready;
         o_bvalid <= next_bvalid;
         o_bresp <= next_bresp;
         o_arready <= next_arready;
         o_rvalid <= next_rvalid;
         o_rresp <= next_rresp;
         o_rdata <= next_rdata;
         addr_reg <= next_addr_reg;
         wbyte <= next_wbyte;
         cmd <= next_cmd;
      end
   end

   // Polling sequencer; commands while busy are dropped
   always_comb begin
      next_state = state;
      next_go = 1'b0;
      next_wr = wr;
      next_bdata = bdata;
      next_t1 = t1;
      next_done = done;
      next_fail = fail;
      next_tout = tout_seen;
      next_from_poll = from_poll;
      next_last_rd = last_rd;
      next_rd_cnt = rd_cnt;
      case (state)
         ST_IDLE: begin
            if (cmd != 4'h0) begin
               next_go = 1'b1;
               next_done = 1'b0;
               next_fail = 1'b0;
               next_tout = 1'b0;
               next_from_poll = 1'b0;
               next_rd_cnt = 2'd0;
               // Reset and write outrank read, so a combined order still writes
               next_wr = !cmd[CMD_POLL] && (cmd[CMD_RST] || cmd[CMD_WR]);
               next_bdata = cmd[CMD_RST] ? RESET_CMD : wbyte;
            end
            if (cmd[CMD_POLL]) begin
               next_state = ST_RD1;
            end else if (cmd[CMD_RST]) begin
               next_state = ST_RST;
            end else if (cmd[CMD_WR] || cmd[CMD_RD]) begin
               next_state = ST_ONE;
            end
         end
         ST_RD1, ST_RD3: begin
            if (bc_done) begin
               next_t1 = bc_rdata[PTOG_BIT];
               next_last_rd = bc_rdata;
               next_rd_cnt = (rd_cnt == 2'd3) ? rd_cnt : rd_cnt + 2'd1;
               next_go = 1'b1;
               next_state = (state == ST_RD1) ? ST_RD2 : ST_RD4;
            end
         end
         ST_RD2: begin
            if (bc_done) begin
               next_last_rd = bc_rdata;
               next_rd_cnt = (rd_cnt == 2'd3) ? rd_cnt : rd_cnt + 2'd1;
               if (bc_rdata[PTOG_BIT] == t1) begin
                  next_done = 1'b1;
                  next_state = ST_IDLE;
               end else if (bc_rdata[TOUT_BIT]) begin
                  next_tout = 1'b1;
                  next_go = 1'b1;
                  next_state = ST_RD3;
               end else begin
                  // Still busy: keep monitoring from the first read
                  next_go = 1'b1;
                  next_state = ST_RD1;
               end
            end
         end
         ST_RD4: begin
            if (bc_done) begin
               next_last_rd = bc_rdata;
               if (bc_rdata[PTOG_BIT] == t1) begin
                  next_done = 1'b1;
                  next_state = ST_IDLE;
               end else begin
                  next_go = 1'b1;
                  next_wr = 1'b1;
                  next_bdata = RESET_CMD;
                  next_from_poll = 1'b1;
                  next_state = ST_RST;
               end
            end
         end
         ST_RST: begin
            if (bc_done) begin
               next_done = 1'b1;
               next_fail = from_poll;
               next_state = ST_IDLE;
            end
         end
         ST_ONE: begin
            if (bc_done) begin
               next_done = 1'b1;
               next_last_rd = wr ? last_rd : bc_rdata;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         go <= 1'b0;
         wr <= 1'b0;
         bdata <= BYTE_RST;
         t1 <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         tout_seen <= 1'b0;
         from_poll <= 1'b0;
         last_rd <= BYTE_RST;
         rd_cnt <= 2'd0;
      end else begin
         state <= next_state;
         go <= next_go;
         wr <= next_wr;
         bdata <= next_bdata;
         t1 <= next_t1;
         done <= next_done;
         fail <= next_fail;
         tout_seen <= next_tout;
         from_poll <= next_from_poll;
         last_rd <= next_last_rd;
         rd_cnt <= next_rd_cnt;
      end
   end

   fwsr_bus_cycle u_cycle (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_go(go),
      .i_wr(wr),
      .i_addr(addr_reg),
      .i_wdata(bdata),
      .o_done(bc_done),
      .o_rdata(bc_rdata),
      .o_fl_addr(o_fl_addr),
      .o_fl_ce_n(o_fl_ce_n),
      .o_fl_oe_n(o_fl_oe_n),
      .o_fl_we_n(o_fl_we_n),
      .o_fl_dq_out(o_fl_dq_out),
      .o_fl_dq_oe(o_fl_dq_oe),
      .i_fl_dq_in(i_fl_dq_in)
   );

   // Checks on the polling algorithm and the AXI write response
   a_two_reads_min: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(done) && $past(state) == ST_RD2 |-> rd_cnt >= 2'd2) else $error("poll ended before two reads");
   a_tout_recheck: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state == ST_RD2 && bc_done && bc_rdata[PTOG_BIT] != t1 && bc_rdata[TOUT_BIT]
      |=> state == ST_RD3 && tout_seen && go) else $error("timeout seen without recheck");
   a_fail_resets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state == ST_RD4 && bc_done && bc_rdata[PTOG_BIT] != t1
      |=> state == ST_RST && bdata == RESET_CMD ##[1:40] fail) else $error("failure not followed by reset");
   a_fail_cause: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(fail) |-> $past(state) == ST_RST && tout_seen) else $error("fail without reset command");
   a_restart_top: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state == ST_IDLE && cmd[CMD_POLL] |=> state == ST_RD1 && rd_cnt == 2'd0 && !done)
      else $error("poll did not restart at top");
   a_bvalid_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_bvalid && !i_bready |=> o_bvalid) else $error("write response dropped");
   c_poll_ok: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(done) && !fail && !tout_seen);
   c_poll_fail: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(fail));
   c_recheck_ok: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(done) && tout_seen && !fail);
endmodule

/* verif/fwsr_flash_model.sv */
/*
 * Behavioural parallel flash: reports toggle status while an embedded
 * operation runs and stores programmed bytes.
 * Assumes strobes from the poller and a data wire resolved by the bench.
 */
`timescale 1ns/100ps
module fwsr_flash_model (
   input wire logic [16:0] i_addr,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [7:0] i_dq,
   input wire logic i_arm,
   input wire logic [15:0] i_busy_reads,
   input wire logic i_tout,
   input wire logic i_erase,
   output logic [7:0] o_dq
);
   logic [7:0] mem [int];
   logic [15:0] left = 16'h0000;
   logic tog = 1'h0;
   logic tout_on = 1'h0;
   logic erasing = 1'h0;
   logic [7:0] last = 8'h00;
   wire rd = !i_ce_n && !i_oe_n;
   wire wr = !i_ce_n && !i_we_n;
   initial o_dq = 8'h00;
   // Bench starts an embedded operation; read count stands in for time
   always @(posedge i_arm) begin
      left = i_busy_reads;
      tout_on = i_tout;
      erasing = i_erase;
   end
   // Status while busy, array data once finished
   always @(posedge rd) begin
      if (left != 16'h0000 && erasing)
         o_dq = {1'b0, tog, tout_on, 1'b0, 1'b1, tog, 2'b00};
      else if (left != 16'h0000)
         o_dq = {~last[7], tog, tout_on, 5'h00};
      else
         o_dq = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 8'h5a;
   end
   // Toggle flips as each busy read ends; released lines invert, never hold
   always @(negedge rd) begin
      if (left != 16'h0000) begin
         tog = ~tog;
         left = left - 16'h0001;
      end
      o_dq = ~o_dq;
   end
   // Data latched as the write strobe rises
   always @(negedge wr) begin
      if (i_dq == 8'hf0) begin
         left = 16'h0000;
         tout_on = 1'h0;
      end else begin
         last = i_dq;
         // Programming can only clear bits
         mem[int'(i_addr)] = (mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 8'h5a) & i_dq;
      end
   end
endmodule

/* verif/fwsr_poller_tb.sv */
/*
 * Self-checking bench for the flash status poller: AXI4-Lite master
 * tasks, register and refusal cases, a table of poll cases against the
 * flash model, then write and reset cases.
 * Assumes the register map and command bits of the package.
 */
`timescale 1ns/100ps
module fwsr_poller_tb;
   import fwsr_pkg::*;
   typedef struct {logic [15:0] reads; logic tout; logic erase; logic [3:0] stat;} fwsr_row_s;
   // Busy reads, timeout bit, erase, expected timeout-seen/fail/done/busy
   fwsr_row_s rows [4] = '{'{16'h0000, 1'h0, 1'h0, 4'h2}, '{16'h0004, 1'h0, 1'h1, 4'h2},
      '{16'h0002, 1'h1, 1'h0, 4'ha}, '{16'h03e8, 1'h1, 1'h0, 4'he}};
   logic i_ref_clk = 1'h0;
   logic i_rst = 1'h1;
   logic [4:0] awaddr = 5'h00;
   logic [4:0] araddr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, got;
   logic [16:0] fl_addr;
   logic [7:0] dq_out, m_dq;
   logic arm = 1'h0, tout = 1'h0, erase = 1'h0;
   logic [15:0] busy_reads = 16'h0000;
   int err_count = 0, samples_checked = 0, cyc = 0;
   // Shared data wire: poller wins while it drives
   wire [7:0] dq_wire = dq_oe ? dq_out : m_dq;

   fwsr_poller i_fwsr_poller (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .o_fl_addr(fl_addr), .o_fl_ce_n(ce_n), .o_fl_oe_n(oe_n), .o_fl_we_n(we_n),
      .o_fl_dq_out(dq_out), .o_fl_dq_oe(dq_oe), .i_fl_dq_in(dq_wire));
   fwsr_flash_model i_fwsr_flash_model (.i_addr(fl_addr), .i_ce_n(ce_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_dq(dq_wire), .i_arm(arm), .i_busy_reads(busy_reads),
      .i_tout(tout), .i_erase(erase), .o_dq(m_dq));

   // 25 ns clock
   initial begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge i_ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge i_ref_clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      while (bvalid !== 1'h1) @(posedge i_ref_clk);
      r = bresp;
      bready <= 1'h0;
   endtask

   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_ref_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge i_ref_clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      while (rvalid !== 1'h1) @(posedge i_ref_clk);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask

   // Issue one command and read status until done
   task automatic run_cmd(input int bit_no, output logic [31:0] s);
      axi_wr(REG_CTRL, 32'h1 << bit_no, resp);
      do axi_rd(REG_STATUS, s, resp); while (s[1] !== 1'h1);
   endtask

   // Hang guard, well above the expected run length
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'h0;
      axi_rd(REG_STATUS, got, resp);
      chk_word(got, 32'h0);
      axi_rd(REG_RDATA, got, resp);
      chk_word(got, 32'h0);
      axi_wr(REG_ADDR, 32'h0001abcd, resp);
      chk_resp(resp, RESP_OKAY);
      axi_rd(REG_ADDR, got, resp);
      chk_word(got, 32'h0001abcd);
      axi_wr(5'h14, 32'h1, resp);
      chk_resp(resp, RESP_SLVERR);
      axi_rd(5'h14, got, resp);
      chk_resp(resp, RESP_SLVERR);
      $display("test registers ended");
      // Poll cases: done, slow finish, late timeout, stuck failure
      foreach (rows[i]) begin
         @(posedge i_ref_clk);
         busy_reads <= rows[i].reads;
         tout <= rows[i].tout;
         erase <= rows[i].erase;
         arm <= 1'h1;
         @(posedge i_ref_clk);
         arm <= 1'h0;
         run_cmd(CMD_POLL, got);
         chk_word({28'h0, got[3:0]}, {28'h0, rows[i].stat});
         run_cmd(CMD_RD, got);
         axi_rd(REG_RDATA, got, resp);
         chk_word(got, 32'h5a);
         $display("test poll row %0d ended", i);
      end
      // Program a byte, then read it back through the device
      axi_wr(REG_WDATA, 32'h3c, resp);
      run_cmd(CMD_WR, got);
      chk_word({28'h0, got[3:0]}, 32'h2);
      run_cmd(CMD_RD, got);
      axi_rd(REG_RDATA, got, resp);
      chk_word(got, 32'h18);
      // Write and read asked together: the write must win
      axi_wr(REG_WDATA, 32'h0f, resp);
      axi_wr(REG_CTRL, 32'hc, resp);
      do axi_rd(REG_STATUS, got, resp); while (got[1] !== 1'h1);
      run_cmd(CMD_RD, got);
      axi_rd(REG_RDATA, got, resp);
      chk_word(got, 32'h08);
      run_cmd(CMD_RST, got);
      chk_word({28'h0, got[3:0]}, 32'h2);
      $display("test write and reset ended");
      // Reset in the middle of an endless poll
      @(posedge i_ref_clk);
      busy_reads <= 16'h03e8;
      tout <= 1'h0;
      arm <= 1'h1;
      axi_wr(REG_CTRL, 32'h1, resp);
      arm <= 1'h0;
      repeat (60) @(posedge i_ref_clk);
      i_rst <= 1'h1;
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'h0;
      axi_rd(REG_STATUS, got, resp);
      chk_word(got, 32'h0);
      chk_word({29'h0, ce_n, oe_n, we_n}, 32'h7);
      $display("test mid-run reset ended");
      close_out();
   end
endmodule
